/* rtl/tspbi_pkg.sv */
`default_nettype none
package tspbi_pkg;
    localparam int SEG_N     = 4;
    localparam int SEG_W     = 128;
    localparam int MTY_W     = 4;
    localparam int MTY_ERR_W = 3;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MASK   = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATE  = 8'h0C;

    localparam int EV_OVF  = 0;
    localparam int EV_UNF  = 1;
    localparam int EV_N    = 2;
    localparam int CTRL_RST = 0;

    localparam int ST_OVF_BIT = 0;
    localparam int ST_UNF_BIT = 1;
    localparam int ST_RDY_BIT = 2;
    localparam int ST_PKT_LSB = 3;

    localparam logic [EV_N-1:0]   MASK_RST  = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0;

    typedef enum logic [1:0] {
        TSPBI_IDLE  = 2'b00,
        TSPBI_INPKT = 2'b01,
        TSPBI_UNDER = 2'b10
    } tspbi_pkt_t;
endpackage
`default_nettype wire

/* rtl/tspbi_seg.sv */
`default_nettype none
module tspbi_seg (
    input  wire logic                            ena,
    input  wire logic                            sop,
    input  wire logic                            eop,
    input  wire logic                            err,
    input  wire logic [tspbi_pkg::MTY_W-1:0]     mty,
    output logic                                 q_sop,
    output logic                                 q_eop,
    output logic                                 q_err,
    output logic      [tspbi_pkg::MTY_W-1:0]     q_mty
);
    import tspbi_pkg::*;

    always_comb begin
        q_sop = ena & sop;
        q_eop = ena & eop;
        q_err = ena & eop & err;
        q_mty = q_eop ? mty : '0;
        if (q_err) begin
            q_mty[MTY_ERR_W-1:0] = '0;
        end
    end
endmodule
`default_nettype wire

/* rtl/tspbi_top.sv */
`default_nettype none
module tspbi_top #(
    parameter int NSEG = tspbi_pkg::SEG_N,
    parameter int DW   = tspbi_pkg::SEG_W
)(
    input  wire logic                                     sys_clk,
    input  wire logic                                     sys_rst,
    input  wire logic [NSEG-1:0][DW-1:0]                  seg_data,
    input  wire logic [NSEG-1:0]                          seg_ena,
    input  wire logic [NSEG-1:0]                          seg_sop,
    input  wire logic [NSEG-1:0]                          seg_eop,
    input  wire logic [NSEG-1:0]                          seg_err,
    input  wire logic [NSEG-1:0][tspbi_pkg::MTY_W-1:0]    seg_mty,
    output logic                                          tx_ready,
    output logic                                          tx_overflow,
    output logic                                          tx_underflow,
    output logic                                          line_valid,
    input  wire logic                                     line_ready,
    output logic      [NSEG-1:0][DW-1:0]                  line_data,
    output logic      [NSEG-1:0]                          line_sop,
    output logic      [NSEG-1:0]                          line_eop,
    output logic      [NSEG-1:0]                          line_err,
    output logic      [NSEG-1:0][tspbi_pkg::MTY_W-1:0]    line_mty,
    output logic                                          line_err_block,
    input  wire logic [tspbi_pkg::ADDR_W-1:0]             reg_addr,
    input  wire logic [tspbi_pkg::DATA_W-1:0]             reg_wdata,
    input  wire logic                                     reg_wr,
    input  wire logic                                     reg_rd,
    output logic      [tspbi_pkg::DATA_W-1:0]             reg_rdata,
    output logic                                          irq
);
    import tspbi_pkg::*;

    typedef struct packed {
        tspbi_pkt_t                  pkt;
        logic                        corrupt;
        logic                        rdy;
        logic                        ovf;
        logic                        unf;
        logic                        lv;
        logic [NSEG-1:0][DW-1:0]     ldata;
        logic [NSEG-1:0]             lsop;
        logic [NSEG-1:0]             leop;
        logic [NSEG-1:0]             lerr;
        logic [NSEG-1:0][MTY_W-1:0]  lmty;
        logic                        lerrblk;
        logic [EV_N-1:0]             sts;
        logic [EV_N-1:0]             msk;
        logic                        irq;
        logic [DATA_W-1:0]           rdata;
    } tspbi_state_t;

    tspbi_state_t state_ff;
    tspbi_state_t nxt_state;

    logic [NSEG-1:0]             q_sop;
    logic [NSEG-1:0]             q_eop;
    logic [NSEG-1:0]             q_err;
    logic [NSEG-1:0][MTY_W-1:0]  q_mty;

    // Per-segment qualifier masking
    genvar g;
    generate
        for (g = 0; g < NSEG; g++) begin : g_seg
            tspbi_seg u_seg (
                .ena   (seg_ena[g]),
                .sop   (seg_sop[g]),
                .eop   (seg_eop[g]),
                .err   (seg_err[g]),
                .mty   (seg_mty[g]),
                .q_sop (q_sop[g]),
                .q_eop (q_eop[g]),
                .q_err (q_err[g]),
                .q_mty (q_mty[g])
            );
        end
    endgenerate

    logic            accept;
    logic            any_ena;
    logic            in_pkt;
    logic            corrupt;
    logic            soft_rst;
    logic [EV_N-1:0] ev;

    always_comb begin
        nxt_state = state_ff;
        any_ena   = |seg_ena;
        soft_rst  = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_RST];
        ev        = '0;

        // Output beat is free or draining this cycle
        accept = !state_ff.lv || line_ready;
        if (state_ff.lv && line_ready) begin
            nxt_state.lv = 1'b0;
        end

        if (any_ena && !accept) begin
            nxt_state.ovf = 1'b1;
            ev[EV_OVF]    = 1'b1;
        end

        // Packet tracking, segment zero first
        in_pkt  = (state_ff.pkt != TSPBI_IDLE);
        corrupt = state_ff.corrupt;
        for (int s = 0; s < NSEG; s++) begin
            if (q_sop[s]) begin
                in_pkt  = 1'b1;
                corrupt = 1'b0;
            end
            if (q_eop[s]) begin
                in_pkt  = 1'b0;
            end
        end

        if (any_ena && accept) begin
            nxt_state.lv    = 1'b1;
            nxt_state.lsop  = q_sop;
            nxt_state.leop  = q_eop;
            nxt_state.lmty  = q_mty;
            for (int s = 0; s < NSEG; s++) begin
                nxt_state.ldata[s] = seg_ena[s] ? seg_data[s] : '0;
                nxt_state.lerr[s]  = q_err[s] || (q_eop[s] && state_ff.corrupt);
            end
        end

        nxt_state.unf = 1'b0;
        if (in_pkt && !any_ena && state_ff.rdy) begin
            nxt_state.unf = 1'b1;
            corrupt       = 1'b1;
            if (state_ff.pkt != TSPBI_UNDER) begin
                ev[EV_UNF] = 1'b1;
            end
        end
        nxt_state.corrupt = corrupt && in_pkt;

        case (state_ff.pkt)
            TSPBI_IDLE, TSPBI_INPKT, TSPBI_UNDER: begin
                if (nxt_state.unf) begin
                    nxt_state.pkt = TSPBI_UNDER;
                end else if (in_pkt) begin
                    nxt_state.pkt = TSPBI_INPKT;
                end else begin
                    nxt_state.pkt = TSPBI_IDLE;
                end
            end
            default: begin
                nxt_state.pkt = TSPBI_IDLE;
            end
        endcase

        nxt_state.lerrblk = (nxt_state.pkt == TSPBI_UNDER);

        nxt_state.rdy = !nxt_state.lv || line_ready;

        // Register writes; hardware set beats write-one clear
        if (reg_wr && reg_addr == REG_MASK) begin
            nxt_state.msk = reg_wdata[EV_N-1:0];
        end
        if (reg_wr && reg_addr == REG_STATUS) begin
            nxt_state.sts = state_ff.sts & ~reg_wdata[EV_N-1:0];
        end
        nxt_state.sts = nxt_state.sts | ev;

        if (soft_rst) begin
            nxt_state.ovf     = 1'b0;
            nxt_state.unf     = 1'b0;
            nxt_state.lv      = 1'b0;
            nxt_state.pkt     = TSPBI_IDLE;
            nxt_state.corrupt = 1'b0;
            nxt_state.lerrblk = 1'b0;
            nxt_state.rdy     = 1'b1;
        end

        nxt_state.irq = |(nxt_state.sts & nxt_state.msk);

        nxt_state.rdata = RDATA_NONE;
        if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: nxt_state.rdata[EV_N-1:0] = state_ff.sts;
                REG_MASK:   nxt_state.rdata[EV_N-1:0] = state_ff.msk;
                REG_STATE: begin
                    nxt_state.rdata[ST_OVF_BIT] = state_ff.ovf;
                    nxt_state.rdata[ST_UNF_BIT] = state_ff.unf;
                    nxt_state.rdata[ST_RDY_BIT] = state_ff.rdy;
                    nxt_state.rdata[ST_PKT_LSB +: $bits(tspbi_pkt_t)] = state_ff.pkt;
                end
                default:    nxt_state.rdata = RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff         <= '0;
            state_ff.pkt     <= TSPBI_IDLE;
            state_ff.rdy     <= 1'b1;
            state_ff.msk     <= MASK_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tx_ready       = state_ff.rdy;
    assign tx_overflow    = state_ff.ovf;
    assign tx_underflow   = state_ff.unf;
    assign line_valid     = state_ff.lv;
    assign line_data      = state_ff.ldata;
    assign line_sop       = state_ff.lsop;
    assign line_eop       = state_ff.leop;
    assign line_err       = state_ff.lerr;
    assign line_mty       = state_ff.lmty;
    assign line_err_block = state_ff.lerrblk;
    assign reg_rdata      = state_ff.rdata;
    assign irq            = state_ff.irq;
endmodule
`default_nettype wire

/* bench/tspbi_asserts.sv */
`default_nettype none
module tspbi_asserts #(
    parameter int NSEG = tspbi_pkg::SEG_N,
    parameter int DW   = tspbi_pkg::SEG_W
)(
    input  wire logic                                     sys_clk,
    input  wire logic                                     sys_rst,
    input  wire logic [NSEG-1:0][DW-1:0]                  seg_data,
    input  wire logic [NSEG-1:0]                          seg_ena,
    input  wire logic [NSEG-1:0]                          seg_eop,
    input  wire logic [NSEG-1:0]                          seg_err,
    input  wire logic [NSEG-1:0][tspbi_pkg::MTY_W-1:0]    seg_mty,
    input  wire logic                                     tx_overflow,
    input  wire logic                                     tx_underflow,
    input  wire logic                                     line_valid,
    input  wire logic                                     line_ready,
    input  wire logic [NSEG-1:0][DW-1:0]                  line_data,
    input  wire logic [NSEG-1:0]                          line_err,
    input  wire logic [NSEG-1:0][tspbi_pkg::MTY_W-1:0]    line_mty,
    input  wire logic                                     line_err_block,
    input  wire logic [tspbi_pkg::ADDR_W-1:0]             reg_addr,
    input  wire logic [tspbi_pkg::DATA_W-1:0]             reg_wdata,
    input  wire logic                                     reg_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import tspbi_pkg::*;
    logic acc;
    logic srst;
    assign acc  = |seg_ena && (!line_valid || line_ready);
    assign srst = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RST];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_OVF_SET: assert property (|seg_ena && line_valid && !line_ready && !srst
        |=> tx_overflow)
        else $error("overflow not raised");
    AST_OVF_HOLD: assert property (tx_overflow && !srst |=> tx_overflow)
        else $error("overflow dropped");
    AST_UNF_BLK: assert property (tx_underflow |-> line_err_block)
        else $error("no error blocks in underflow");
    AST_CAP0: assert property (acc && seg_ena[0] && !srst
        |=> line_valid && line_data[0] == $past(seg_data[0]))
        else $error("segment 0 not captured");
    AST_ENA_OFF: assert property (acc && !seg_ena[1] |=> line_data[1] == '0 && !line_err[1])
        else $error("disabled segment leaked");
    AST_ORDER: assert property (acc && seg_ena[3] |=> line_data[3] == $past(seg_data[3]))
        else $error("segment 3 misplaced");
    AST_MTY: assert property (acc && seg_ena[1] && seg_eop[1] && !seg_err[1]
        |=> line_mty[1] == $past(seg_mty[1]))
        else $error("empty count lost");
    AST_ERR: assert property (acc && seg_ena[2] && seg_eop[2] && seg_err[2]
        |=> line_err[2] && line_mty[2][2:0] == 3'h0)
        else $error("error end not marked");
endmodule
`default_nettype wire

/* bench/tspbi_sink.sv */
`default_nettype none
module tspbi_sink (
    input  wire logic stall,
    output logic      line_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Downstream consumer, stalls on command
    assign line_ready = !stall;
endmodule
`default_nettype wire

/* bench/tspbi_top_bench.sv */
`default_nettype none
module tspbi_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tspbi_pkg::*;
    logic                          sys_clk = 1'b0;
    logic                          sys_rst = 1'b1;
    logic [SEG_N-1:0][SEG_W-1:0]   seg_data = '0;
    logic [SEG_N-1:0]              seg_ena = '0, seg_sop = '0, seg_eop = '0, seg_err = '0;
    logic [SEG_N-1:0][MTY_W-1:0]   seg_mty = '0;
    logic [ADDR_W-1:0]             reg_addr = '0;
    logic [DATA_W-1:0]             reg_wdata = '0;
    logic                          reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
    logic                          tx_ready, tx_overflow, tx_underflow, line_valid, line_ready;
    logic                          line_err_block, irq;
    logic [SEG_N-1:0][SEG_W-1:0]   line_data;
    logic [SEG_N-1:0]              line_sop, line_eop, line_err;
    logic [SEG_N-1:0][MTY_W-1:0]   line_mty;
    logic [DATA_W-1:0]             reg_rdata;
    int                            n_errors = 0, cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    tspbi_sink u_tspbi_sink (.stall(stall), .line_ready(line_ready));
    tspbi_top u_tspbi_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .seg_data(seg_data), .seg_ena(seg_ena),
        .seg_sop(seg_sop), .seg_eop(seg_eop), .seg_err(seg_err), .seg_mty(seg_mty),
        .tx_ready(tx_ready), .tx_overflow(tx_overflow), .tx_underflow(tx_underflow),
        .line_valid(line_valid), .line_ready(line_ready), .line_data(line_data),
        .line_sop(line_sop), .line_eop(line_eop), .line_err(line_err), .line_mty(line_mty),
        .line_err_block(line_err_block), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    task automatic chk(input logic [SEG_W-1:0] got, input logic [SEG_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Each task leaves 1 ns after the edge that took its request
    task automatic push(input logic [3:0] ena, input logic [3:0] sop, input logic [3:0] eop,
                        input logic [3:0] err, input logic [15:0] mty, input logic [7:0] tag);
        seg_ena <= ena;
        seg_sop <= sop;
        seg_eop <= eop;
        seg_err <= err;
        seg_mty <= mty;
        for (int i = 0; i < SEG_N; i++)
            seg_data[i] <= {120'h0, tag + 8'(i)};
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle();
        seg_ena <= '0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic t_pkt();
        push(4'hF, 4'h1, 4'h0, 4'h0, 16'h0, 8'h10);
        chk(line_valid, 1'h1);
        chk(line_sop, 4'h1);
        chk(line_data[3], 128'h13);
        push(4'h7, 4'h0, 4'h4, 4'h4, 16'h0F00, 8'h20);
        chk(line_eop, 4'h4);
        chk(line_err, 4'h4);
        chk(line_mty[2], 4'h8);
        chk(line_data[3], '0);
        push(4'h3, 4'h1, 4'h2, 4'h0, 16'h00A0, 8'h30);
        chk(line_mty[1], 4'hA);
        idle();
        chk(line_valid, 1'h0);
        chk(tx_underflow, 1'b0);
        $display("test pkt done");
    endtask
    task automatic t_unf();
        push(4'hF, 4'h1, 4'h0, 4'h0, 16'h0, 8'h40);
        idle();
        chk(tx_underflow, 1'b1);
        chk(line_err_block, 1'b1);
        push(4'h1, 4'h0, 4'h1, 4'h0, 16'h0, 8'h50);
        chk(line_err, 4'h1);
        idle();
        rd(REG_STATUS, 32'h2);
        wr(REG_STATUS, 32'h2);
        rd(REG_STATUS, 32'h0);
        $display("test unf done");
    endtask
    task automatic t_ovf();
        wr(REG_MASK, 32'h1);
        stall <= 1'b1;
        push(4'h1, 4'h1, 4'h1, 4'h0, 16'h0, 8'h60);
        chk(tx_ready, 1'h0);
        push(4'h1, 4'h1, 4'h1, 4'h0, 16'h0, 8'h70);
        chk(tx_overflow, 1'b1);
        chk(line_data[0], 128'h60);
        idle();
        chk(irq, 1'b1);
        rd(REG_STATUS, 32'h1);
        rd(8'hF0, 32'h0);
        chk(tx_overflow, 1'b1);
        stall <= 1'b0;
        wr(REG_CTRL, 32'h1);
        chk(tx_ready, 1'h1);
        wr(REG_STATUS, 32'h1);
        rd(REG_STATUS, 32'h0);
        chk(tx_overflow, 1'b0);
        chk(irq, 1'b0);
        $display("test ovf done");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        rd(REG_STATE, 32'h4);
        t_pkt();
        t_unf();
        t_ovf();
        give_verdict();
    end
endmodule
bind tspbi_top tspbi_asserts #(.NSEG(NSEG), .DW(DW)) u_tspbi_asserts (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .seg_data(seg_data), .seg_ena(seg_ena),
    .seg_eop(seg_eop), .seg_err(seg_err), .seg_mty(seg_mty), .tx_overflow(tx_overflow),
    .tx_underflow(tx_underflow), .line_valid(line_valid), .line_ready(line_ready),
    .line_data(line_data), .line_err(line_err), .line_mty(line_mty),
    .line_err_block(line_err_block), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr));
`default_nettype wire
